/* File: core/usb_ep_ctrl.sv */
// control and status slice of one usb device endpoint
//
// Summary of operation
// - setup packet stored sets setup flag, event
// - write zero clears setup flag
// - data out refused while setup flag set
// - host stall handshake acked sets halt flag
// - write zero clears halt flag; event drops once no other flag is set
// - iso crc error sets same bit
// - firmware sets tx ready, blocks fifo writes
// - host received in payload sets tx complete
// - write one forces stall handshake
// - stall meaning depends on kind, ack reported
// - bank one reception sets bank one flag
// - direction bit selects out or in stage
// - three bit endpoint kind read write
// - toggle bit reads data0 zero, data1 one
// - endpoint enable read write
// - out packets stored, byte count 10:0
// - fifo port moves one byte per access
// - transceiver power off bit
// - write zero clears tx complete
// - bank zero reception sets bank zero flag
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "usb_ep_consts.svh"
module usb_ep_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_pkt_end,
   input wire logic rx_pkt_setup,
   input wire logic rx_pkt_crc_bad,
   input wire logic rx_pkt_toggle,
   input wire logic tx_byte_req,
   input wire logic tx_ack,
   input wire logic halt_ack,
   output logic rx_accept,
   output logic tx_pkt_avail,
   output logic [7:0] tx_byte,
   output logic halt_request,
   output logic ep_event,
   output logic transceiver_off,
   output logic ep_active
);
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic usb_ep_pkg::reg_sel_t decode(input logic [11:0] a);
      usb_ep_pkg::reg_sel_t s;
      s = usb_ep_pkg::SEL_NONE;
      case (a)
         `EP_CSR_OFF: begin
            s = usb_ep_pkg::SEL_CSR;
         end
         `EP_FIFO_OFF: begin
            s = usb_ep_pkg::SEL_FIFO;
         end
         `EP_TXVC_OFF: begin
            s = usb_ep_pkg::SEL_TXVC;
         end
         default: begin
            s = usb_ep_pkg::SEL_NONE;
         end
      endcase
      return s;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic setup_q;
   logic halt_q;
   logic txrdy_q;
   logic tx_complete_q;
   logic force_q;
   logic bk0_q;
   logic bk1_q;
   logic dir_q;
   usb_ep_pkg::kind_t kind_q;
   logic tgl_q;
   logic on_q;
   logic phy_off_q;
   logic bank_sel_q;
   logic rx_accept_q;
   logic tx_avail_q;
   usb_ep_pkg::byte_t tx_byte_q;
   logic event_q;

   logic wr_stb;
   logic rd_stb;
   logic wr_csr;
   logic wr_fifo;
   logic wr_txvc;
   logic rd_fifo;
   logic [31:0] rdata_next;
   logic err_next;
   logic is_ctrl;
   logic is_iso;
   logic ping_pong;
   logic data_end;
   logic [`CNT_W-1:0] rx_cnt;

   ep_fifo_if fifo ();

   // ----------------------------------------
   // bus port and storage
   // ----------------------------------------
   ep_apb_port u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .rdata_next(rdata_next),
      .err_next(err_next),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb)
   );

   ep_fifo u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .f(fifo)
   );

   // ----------------------------------------
   // strobes and kind decode
   // ----------------------------------------
   assign wr_csr = wr_stb && (decode(paddr) == usb_ep_pkg::SEL_CSR);
   assign wr_fifo = wr_stb && (decode(paddr) == usb_ep_pkg::SEL_FIFO);
   assign wr_txvc = wr_stb && (decode(paddr) == usb_ep_pkg::SEL_TXVC);
   assign rd_fifo = rd_stb && (decode(paddr) == usb_ep_pkg::SEL_FIFO);
   assign is_ctrl = (kind_q == `KIND_CONTROL);
   assign is_iso = (kind_q[1:0] == `KIND_ISO_LOW);
   assign ping_pong = !is_ctrl;
   assign data_end = rx_pkt_end && !rx_pkt_setup;
   assign err_next = (decode(paddr) == usb_ep_pkg::SEL_NONE);
   assign rx_cnt = `CNT_W'(fifo.level);

   // ----------------------------------------
   // fifo access: link pushes win over firmware
   // ----------------------------------------
   always_comb begin
      fifo.push = 1'b0;
      fifo.push_data = 8'h00;
      if (rx_byte_valid && on_q) begin
         fifo.push = 1'b1;
         fifo.push_data = rx_byte;
      end else if (wr_fifo && !txrdy_q) begin
         fifo.push = 1'b1;
         fifo.push_data = pwdata[7:0];
      end
   end

   assign fifo.pop = rd_fifo || tx_byte_req;
   assign fifo.clr = !on_q;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (decode(paddr))
         usb_ep_pkg::SEL_CSR: begin
            rdata_next[`CSR_TX_COMPLETE] = tx_complete_q;
            rdata_next[`CSR_BK0] = bk0_q;
            rdata_next[`CSR_SETUP] = setup_q;
            rdata_next[`CSR_HALT] = halt_q;
            rdata_next[`CSR_TXRDY] = txrdy_q;
            rdata_next[`CSR_BK1] = bk1_q;
            rdata_next[`CSR_DIR] = dir_q;
            rdata_next[`CSR_KIND_MSB:`CSR_KIND_LSB] = kind_q;
            rdata_next[`CSR_TGL] = tgl_q;
            rdata_next[`CSR_ON] = on_q;
            rdata_next[`CSR_CNT_MSB:`CSR_CNT_LSB] = rx_cnt;
         end
         usb_ep_pkg::SEL_FIFO: begin
            rdata_next[7:0] = fifo.head;
         end
         usb_ep_pkg::SEL_TXVC: begin
            rdata_next[`TXVC_OFF_BIT] = phy_off_q;
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------
   // setup flag
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_q <= 1'b0;
      end else if (rx_pkt_end && rx_pkt_setup) begin
         setup_q <= 1'b1;
      end else if (wr_csr && !pwdata[`CSR_SETUP]) begin
         setup_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // halt acknowledged / iso crc error flag
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'b0;
      end else if (halt_ack && !is_iso) begin
         halt_q <= 1'b1;
      end else if (data_end && is_iso && rx_pkt_crc_bad) begin
         halt_q <= 1'b1;
      end else if (wr_csr && !pwdata[`CSR_HALT]) begin
         halt_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // forced stall request
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_q <= 1'b0;
      end else if (wr_csr && pwdata[`CSR_FORCE]) begin
         force_q <= 1'b1;
      end else if (halt_ack) begin
         force_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // in packet ready and complete
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txrdy_q <= 1'b0;
      end else if (wr_csr && pwdata[`CSR_TXRDY]) begin
         txrdy_q <= 1'b1;
      end else if (tx_ack) begin
         txrdy_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_complete_q <= 1'b0;
      end else if (tx_ack) begin
         tx_complete_q <= 1'b1;
      end else if (wr_csr && !pwdata[`CSR_TX_COMPLETE]) begin
         tx_complete_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // receive banks
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bk0_q <= 1'b0;
         bk1_q <= 1'b0;
         bank_sel_q <= 1'b0;
      end else begin
         if (data_end && !(ping_pong && bank_sel_q)) begin
            bk0_q <= 1'b1;
         end else if (wr_csr && !pwdata[`CSR_BK0]) begin
            bk0_q <= 1'b0;
         end
         if (data_end && ping_pong && bank_sel_q) begin
            bk1_q <= 1'b1;
         end else if (wr_csr && !pwdata[`CSR_BK1]) begin
            bk1_q <= 1'b0;
         end
         if (data_end && ping_pong) begin
            bank_sel_q <= !bank_sel_q;
         end
      end
   end

   // ----------------------------------------
   // configuration bits
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= 1'b0;
         kind_q <= `KIND_RESET;
         on_q <= 1'b0;
      end else if (wr_csr) begin
         dir_q <= pwdata[`CSR_DIR];
         kind_q <= pwdata[`CSR_KIND_MSB:`CSR_KIND_LSB];
         on_q <= pwdata[`CSR_ON];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_off_q <= 1'b0;
      end else if (wr_txvc) begin
         phy_off_q <= pwdata[`TXVC_OFF_BIT];
      end
   end

   // ----------------------------------------
   // data toggle
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgl_q <= 1'b0;
      end else if (!on_q) begin
         tgl_q <= 1'b0;
      end else if (rx_pkt_end) begin
         tgl_q <= rx_pkt_toggle;
      end else if (tx_ack) begin
         tgl_q <= !tgl_q;
      end
   end

   // ----------------------------------------
   // link side outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_accept_q <= 1'b0;
         tx_avail_q <= 1'b0;
         event_q <= 1'b0;
      end else begin
         rx_accept_q <= on_q && !setup_q && !bk0_q && !bk1_q && !txrdy_q
                        && !(is_ctrl && dir_q);
         tx_avail_q <= on_q && txrdy_q && !(is_ctrl && !dir_q);
         event_q <= setup_q || halt_q || tx_complete_q || bk0_q || bk1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_byte_q <= 8'h00;
      end else if (tx_byte_req) begin
         tx_byte_q <= fifo.head;
      end
   end

   assign rx_accept = rx_accept_q;
   assign tx_pkt_avail = tx_avail_q;
   assign tx_byte = tx_byte_q;
   assign halt_request = force_q;
   assign ep_event = event_q;
   assign transceiver_off = phy_off_q;
   assign ep_active = on_q;
endmodule

/* File: shared/usb_ep_consts.svh */
// offsets, field positions and reset values of the endpoint slice
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EP_CSR_OFF 12'h000
`define EP_FIFO_OFF 12'h004
`define EP_TXVC_OFF 12'h008

// ----------------------------------------
// endpoint_ctrl_status fields
// ----------------------------------------
`define CSR_TX_COMPLETE 0
`define CSR_BK0 1
`define CSR_SETUP 2
`define CSR_HALT 3
`define CSR_TXRDY 4
`define CSR_FORCE 5
`define CSR_BK1 6
`define CSR_DIR 7
`define CSR_KIND_LSB 8
`define CSR_KIND_MSB 10
`define CSR_TGL 11
`define CSR_ON 15
`define CSR_CNT_LSB 16
`define CSR_CNT_MSB 26

// ----------------------------------------
// transceiver_control fields, kinds, sizes
// ----------------------------------------
`define TXVC_OFF_BIT 8
`define KIND_CONTROL 3'h0
`define KIND_ISO_LOW 2'h1
`define KIND_RESET 3'h0
`define FIFO_AW 6
`define FIFO_DEPTH 64
`define CNT_W 11

`endif

/* File: shared/usb_ep_pkg.sv */
// types shared by the endpoint slice
package usb_ep_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] kind_t;
   typedef enum logic [1:0] {
      SEL_CSR,
      SEL_FIFO,
      SEL_TXVC,
      SEL_NONE
   } reg_sel_t;
endpackage

/* File: shared/ep_fifo_if.sv */
// byte fifo carrier between endpoint control and its storage
`timescale 1ns/100ps
`include "usb_ep_consts.svh"
interface ep_fifo_if;
   logic push;
   usb_ep_pkg::byte_t push_data;
   logic pop;
   logic clr;
   usb_ep_pkg::byte_t head;
   logic [`FIFO_AW:0] level;
   logic full;
   logic empty;
   modport owner (
      input push, push_data, pop, clr,
      output head, level, full, empty
   );
   modport user (
      output push, push_data, pop, clr,
      input head, level, full, empty
   );
endinterface

/* File: core/ep_fifo.sv */
// byte fifo memory of one endpoint
`timescale 1ns/100ps
`include "usb_ep_consts.svh"
module ep_fifo (
   input wire logic pclk,
   input wire logic presetn,
   ep_fifo_if.owner f
);
   usb_ep_pkg::byte_t mem [`FIFO_DEPTH];
   logic [`FIFO_AW-1:0] wp_q;
   logic [`FIFO_AW-1:0] rp_q;
   logic [`FIFO_AW:0] lvl_q;
   logic do_push;
   logic do_pop;

   assign do_push = f.push && !f.full;
   assign do_pop = f.pop && !f.empty;
   assign f.head = mem[rp_q];
   assign f.level = lvl_q;
   assign f.full = (lvl_q == (`FIFO_AW+1)'(`FIFO_DEPTH));
   assign f.empty = (lvl_q == '0);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem[wp_q] <= f.push_data;
      end
   end

   // ----------------------------------------
   // pointers and level
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q <= '0;
         rp_q <= '0;
         lvl_q <= '0;
      end else if (f.clr) begin
         wp_q <= '0;
         rp_q <= '0;
         lvl_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (do_push && !do_pop) begin
            lvl_q <= lvl_q + 1'b1;
         end else if (do_pop && !do_push) begin
            lvl_q <= lvl_q - 1'b1;
         end
      end
   end
endmodule

/* File: core/ep_apb_port.sv */
// apb handshake with one wait state and registered read data
`timescale 1ns/100ps
module ep_apb_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] rdata_next,
   input wire logic err_next,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic wr_stb,
   output logic rd_stb
);
   // ----------------------------------------
   // one wait state, data caught with pready
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite) ? rdata_next : 32'h0000_0000;
         pslverr <= psel && penable && !pready && err_next;
      end
   end

   assign wr_stb = psel && penable && pready && pwrite;
   assign rd_stb = psel && penable && pready && !pwrite;
endmodule

/* File: verification/usb_ep_ctrl_checker.sv */
// assertions on the ports of the endpoint slice
`timescale 1ns/100ps
module usb_ep_ctrl_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic rx_pkt_end,
   input wire logic rx_pkt_setup,
   input wire logic tx_ack,
   input wire logic halt_ack,
   input wire logic rx_accept,
   input wire logic tx_pkt_avail,
   input wire logic halt_request,
   input wire logic ep_event,
   input wire logic transceiver_off,
   input wire logic ep_active
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic fw;
   assign wr = psel && penable && pready && pwrite;
   assign fw = wr && paddr == 12'h000 && pwdata[5];
   property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
   a_wait: assert property (p_wait) else $error("apb wait state wrong");
   property p_setup; rx_pkt_end && rx_pkt_setup && ep_active |=> ##1 ep_event && !rx_accept; endproperty
   a_setup: assert property (p_setup) else $error("setup not flagged");
   property p_bank; rx_pkt_end && !rx_pkt_setup && ep_active |=> ##1 ep_event; endproperty
   a_bank: assert property (p_bank) else $error("out packet not flagged");
   property p_txack; tx_ack && tx_pkt_avail |=> ##1 !tx_pkt_avail && ep_event; endproperty
   a_txack: assert property (p_txack) else $error("in completion wrong");
   property p_halt; halt_ack |=> ##1 !halt_request; endproperty
   a_halt: assert property (p_halt) else $error("stall kept after ack");
   property p_force; $rose(halt_request) |-> $past(fw) || $past(fw, 2); endproperty
   a_force: assert property (p_force) else $error("stall without request");
   property p_txvc; wr && paddr == 12'h008 |=> transceiver_off == $past(pwdata[8]); endproperty
   a_txvc: assert property (p_txvc) else $error("transceiver bit wrong");
   property p_on; wr && paddr == 12'h000 |=> ep_active == $past(pwdata[15]); endproperty
   a_on: assert property (p_on) else $error("enable bit wrong");
   c_setup: cover property (rx_pkt_end && rx_pkt_setup);
   c_halt: cover property (halt_ack);
   c_tx: cover property (tx_ack);
endmodule

bind usb_ep_ctrl usb_ep_ctrl_checker chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .pready, .rx_pkt_end, .rx_pkt_setup, .tx_ack, .halt_ack, .rx_accept,
   .tx_pkt_avail, .halt_request, .ep_event, .transceiver_off, .ep_active);

/* File: verification/usb_host_model.sv */
// behavioural usb host on the link side of the endpoint
`timescale 1ns/100ps
module usb_host_model (
   input wire logic pclk,
   input wire logic rx_accept,
   input wire logic tx_pkt_avail,
   input wire logic [7:0] tx_byte,
   input wire logic halt_request,
   output logic rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic rx_pkt_end,
   output logic rx_pkt_setup,
   output logic rx_pkt_crc_bad,
   output logic rx_pkt_toggle,
   output logic tx_byte_req,
   output logic tx_ack,
   output logic halt_ack
);
   // ----------------------------------------
   // host transactions
   // ----------------------------------------
   logic nak;
   logic [7:0] got [$];
   initial begin
      {rx_byte_valid, rx_pkt_end, rx_pkt_setup, rx_pkt_crc_bad} = 4'h0;
      {rx_pkt_toggle, tx_byte_req, tx_ack, halt_ack, nak} = 5'h0;
      rx_byte = 8'h00;
   end
   task automatic send(input int n, input logic [7:0] b, input logic s, t, c);
      int k;
      k = 0;
      while (!s && rx_accept !== 1'h1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      nak = (k == 40);
      if (!nak) begin
         for (int i = 0; i < n; i++) begin
            rx_byte_valid <= 1'h1;
            rx_byte <= b + 8'(i);
            @(posedge pclk);
         end
         rx_byte_valid <= 1'h0;
         rx_byte <= ~rx_byte;
         rx_pkt_end <= 1'h1;
         {rx_pkt_setup, rx_pkt_toggle, rx_pkt_crc_bad} <= {s, t, c};
         @(posedge pclk);
         rx_pkt_end <= 1'h0;
      end
   endtask
   task automatic take(input int n);
      int k;
      k = 0;
      got = {};
      while (tx_pkt_avail !== 1'h1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      for (int i = 0; i < n; i++) begin
         tx_byte_req <= 1'h1;
         @(posedge pclk);
         tx_byte_req <= 1'h0;
         @(posedge pclk);
         got.push_back(tx_byte);
      end
      tx_ack <= 1'h1;
      @(posedge pclk);
      tx_ack <= 1'h0;
   endtask
   task automatic stall_ack();
      int k;
      k = 0;
      while (halt_request !== 1'h1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      halt_ack <= 1'h1;
      @(posedge pclk);
      halt_ack <= 1'h0;
   endtask
endmodule

/* File: verification/test_usb_device_endpoint_control.sv */
// self-checking bench of the endpoint slice
`timescale 1ns/100ps
module test_usb_device_endpoint_control;
   // ----------------------------------------
   // bench
   // ----------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rx_byte_valid, rx_pkt_end, rx_pkt_setup, rx_pkt_crc_bad, rx_pkt_toggle;
   logic tx_byte_req, tx_ack, halt_ack, rx_accept, tx_pkt_avail, halt_request;
   logic ep_event, transceiver_off, ep_active;
   logic [7:0] rx_byte, tx_byte;
   int n_mismatch, checks, cyc;
   usb_ep_ctrl DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .rx_byte_valid, .rx_byte, .rx_pkt_end, .rx_pkt_setup,
      .rx_pkt_crc_bad, .rx_pkt_toggle, .tx_byte_req, .tx_ack, .halt_ack, .rx_accept,
      .tx_pkt_avail, .tx_byte, .halt_request, .ep_event, .transceiver_off, .ep_active);
   usb_host_model host (.pclk, .rx_accept, .tx_pkt_avail, .tx_byte, .halt_request,
      .rx_byte_valid, .rx_byte, .rx_pkt_end, .rx_pkt_setup, .rx_pkt_crc_bad,
      .rx_pkt_toggle, .tx_byte_req, .tx_ack, .halt_ack);
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 20) n_mismatch++;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdk(input string s, input logic [11:0] a, input logic [31:0] m, e);
      apb(1'h0, a, 32'h0);
      chk(s, e, rd & m);
   endtask
   task automatic rdfifo(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++) rdk("fifo", 12'h004, 32'hFFFFFFFF, 32'(b + 8'(i)));
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_kinds();
      logic [2:0] k [7] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
      rdk("csr", 12'h000, 32'hFFFFFFFF, 32'h0);
      rdk("txvc", 12'h008, 32'hFFFFFFFF, 32'h0);
      foreach (k[i]) begin
         wr(12'h000, 32'h80CF | {k[i], 8'h00});
         rdk("kind", 12'h000, 32'h87CF, 32'h8080 | {k[i], 8'h00});
      end
      wr(12'h000, 32'h0);
      rdk("on", 12'h000, 32'h8000, 32'h0);
      chk("ep_active", 32'h0, 32'(ep_active));
   endtask
   task automatic t_banks();
      wr(12'h000, 32'h8200);
      host.send(2, 8'h40, 1'h0, 1'h0, 1'h0);
      rdk("bank0", 12'h000, 32'h07FF0042, 32'h00020002);
      rdfifo(2, 8'h40);
      wr(12'h000, 32'h824D);
      host.send(4, 8'h50, 1'h0, 1'h1, 1'h0);
      rdk("bank1", 12'h000, 32'h07FF0042, 32'h00040040);
      rdfifo(4, 8'h50);
      wr(12'h000, 32'h820F);
      rdk("bank1", 12'h000, 32'h40, 32'h0);
   endtask
   task automatic t_setup();
      wr(12'h000, 32'h8000);
      host.send(8, 8'hA0, 1'h1, 1'h0, 1'h0);
      rdk("setup", 12'h000, 32'h07FF0004, 32'h00080004);
      chk("ep_event", 32'h1, 32'(ep_event));
      chk("ep_active", 32'h1, 32'(ep_active));
      host.send(2, 8'h10, 1'h0, 1'h0, 1'h0);
      chk("nak", 32'h1, 32'(host.nak));
      rdfifo(8, 8'hA0);
      wr(12'h000, 32'h804B);
      rdk("setup", 12'h000, 32'h07FF0004, 32'h0);
      host.send(3, 8'h30, 1'h0, 1'h1, 1'h0);
      rdk("out", 12'h000, 32'h07FF0806, 32'h00030802);
      rdfifo(3, 8'h30);
      wr(12'h000, 32'h8080);
      host.send(1, 8'h01, 1'h0, 1'h0, 1'h0);
      chk("nak", 32'h1, 32'(host.nak));
   endtask
   task automatic t_in();
      wr(12'h000, 32'h8600);
      wr(12'h004, 32'h5A);
      wr(12'h004, 32'hC3);
      wr(12'h000, 32'h8610);
      wr(12'h004, 32'hFF);
      wr(12'h000, 32'h8600);
      rdk("ready", 12'h000, 32'h07FF0011, 32'h00020010);
      host.take(2);
      chk("in0", 32'h5A, 32'(host.got[0]));
      chk("in1", 32'hC3, 32'(host.got[1]));
      rdk("done", 12'h000, 32'h07FF0011, 32'h1);
      wr(12'h000, 32'h8600);
      rdk("done", 12'h000, 32'h1, 32'h0);
   endtask
   task automatic t_halt();
      wr(12'h000, 32'h8220);
      rdk("force", 12'h000, 32'h20, 32'h0);
      chk("halt_request", 32'h1, 32'(halt_request));
      host.stall_ack();
      rdk("halt", 12'h000, 32'h8, 32'h8);
      chk("halt_request", 32'h0, 32'(halt_request));
      wr(12'h000, 32'h8200);
      rdk("halt", 12'h000, 32'h8, 32'h0);
   endtask
   task automatic t_iso();
      wr(12'h000, 32'h8100);
      host.send(1, 8'h77, 1'h0, 1'h0, 1'h1);
      rdk("iso", 12'h000, 32'h8, 32'h8);
      wr(12'h000, 32'h8147);
      rdk("iso", 12'h000, 32'h8, 32'h0);
   endtask
   task automatic t_txvc();
      wr(12'h008, 32'h100);
      rdk("txvc", 12'h008, 32'hFFFFFFFF, 32'h100);
      chk("transceiver_off", 32'h1, 32'(transceiver_off));
      wr(12'h008, 32'h0);
      rdk("txvc", 12'h008, 32'hFFFFFFFF, 32'h0);
      chk("transceiver_off", 32'h0, 32'(transceiver_off));
      rdk("unmapped", 12'h00C, 32'hFFFFFFFF, 32'h0);
      chk("slverr", 32'h1, 32'(er));
   endtask
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_kinds();
      t_banks();
      t_setup();
      t_in();
      t_halt();
      t_iso();
      t_txvc();
      report_and_stop();
   end
endmodule
